// [common/socket_power_map.svh]
`ifndef SOCKET_POWER_MAP_SVH
`define SOCKET_POWER_MAP_SVH

// ----------------------------------------------------------------
// Register offsets in the socket window
// ----------------------------------------------------------------
`define OFS_REVISION 12'h800
`define OFS_IF_STATUS 12'h801
`define OFS_POWER_CONTROL 12'h802
`define OFS_INT_GEN_CONTROL 12'h803

// ----------------------------------------------------------------
// Power control field positions and masks
// ----------------------------------------------------------------
`define PC_OUTPUT_ENABLE_BIT 7
`define PC_AUTO_SWITCH_BIT 5
`define PC_SUPPLY_ENABLE_BIT 4
`define PC_SUPPLY_REQ_HI 4
`define PC_SUPPLY_REQ_LO 3
`define PC_PROG_REQ_HI 1
`define PC_PROG_REQ_LO 0
`define PC_BASIC_RW_MASK 8'hb3
`define PC_ENH_RW_MASK 8'h9b

// ----------------------------------------------------------------
// Status and general control fields
// ----------------------------------------------------------------
`define ST_POWER_BIT 6
`define ST_CD2_BIT 3
`define ST_CD1_BIT 2
`define IGC_PRESERVE_MASK 8'h60

// ----------------------------------------------------------------
// Reset values and encodings
// ----------------------------------------------------------------
`define POWER_CONTROL_RESET 8'h00
`define INT_GEN_RESET 8'h00
`define REVISION_RESET 4'h4
`define REVISION_BASIC 4'h2
`define SUPPLY_REQ_5V 2'h2
`define SUPPLY_REQ_3V3 2'h3
`define PROG_REQ_FOLLOW 2'h1
`define PROG_REQ_12V 2'h2

`endif

// [common/socket_power_pkg.sv]
package socket_power_pkg;

  // Active register layout
  typedef enum logic {LAYOUT_BASIC_MODE, LAYOUT_ENHANCED_MODE} layout_type;

  // Card supply outcome
  typedef enum logic [1:0] {SUPPLY_OFF, SUPPLY_5V, SUPPLY_3V3} supply_type;

  // Programming voltage outcome
  typedef enum logic [1:0] {PROG_OFF, PROG_FOLLOW, PROG_12V} prog_type;

endpackage : socket_power_pkg

// [hdl/pin_sync.sv]
`timescale 1ns/1ns
module pin_sync #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Pins in, synchronised levels out
  input wire logic [WIDTH-1:0] PIN_IN,
  output logic [WIDTH-1:0] PIN_SYNC
);

  logic [WIDTH-1:0] stage1_reg;

  // Two flip-flop synchroniser, reset to the pulled-up idle level
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      stage1_reg <= '1;
      PIN_SYNC <= '1;
    end
    else
    begin
      stage1_reg <= PIN_IN;
      PIN_SYNC <= stage1_reg;
    end
  end

endmodule : pin_sync

// [hdl/power_request_decode.sv]
`timescale 1ns/1ns
`include "socket_power_map.svh"
module power_request_decode (
  // Layout and stored requests
  input wire socket_power_pkg::layout_type LAYOUT,
  input wire logic [7:0] POWER_CONTROL,
  // Conditions from outside the register
  input wire logic SYSTEM_SUPPLY_SELECT,
  input wire logic CARD_PRESENT,
  // Decoded outcome
  output socket_power_pkg::supply_type SUPPLY,
  output socket_power_pkg::prog_type PROG
);

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  wire logic [1:0] supply_req =
    POWER_CONTROL[`PC_SUPPLY_REQ_HI:`PC_SUPPLY_REQ_LO];
  wire logic [1:0] prog_req = POWER_CONTROL[`PC_PROG_REQ_HI:`PC_PROG_REQ_LO];
  wire logic is_basic = (LAYOUT == socket_power_pkg::LAYOUT_BASIC_MODE);

  // Basic supply: enable bit, held off by auto switch without a card
  wire logic basic_on = POWER_CONTROL[`PC_SUPPLY_ENABLE_BIT] &
    (~POWER_CONTROL[`PC_AUTO_SWITCH_BIT] | CARD_PRESENT);
  wire socket_power_pkg::supply_type basic_supply = !basic_on ?
    socket_power_pkg::SUPPLY_OFF : (SYSTEM_SUPPLY_SELECT ?
    socket_power_pkg::SUPPLY_3V3 : socket_power_pkg::SUPPLY_5V);

  // Enhanced supply: 10 is 5 V, 11 is 3.3 V, rest off
  wire socket_power_pkg::supply_type enh_supply =
    (supply_req == `SUPPLY_REQ_5V) ? socket_power_pkg::SUPPLY_5V :
    (supply_req == `SUPPLY_REQ_3V3) ? socket_power_pkg::SUPPLY_3V3 :
    socket_power_pkg::SUPPLY_OFF;

  assign SUPPLY = is_basic ? basic_supply : enh_supply;

  // Vpp request, only honoured with the supply on
  wire logic vcc_on = (SUPPLY != socket_power_pkg::SUPPLY_OFF);
  wire socket_power_pkg::prog_type basic_prog =
    (prog_req == `PROG_REQ_FOLLOW) ? socket_power_pkg::PROG_FOLLOW :
    (prog_req == `PROG_REQ_12V) ? socket_power_pkg::PROG_12V :
    socket_power_pkg::PROG_OFF;
  wire socket_power_pkg::prog_type enh_prog =
    (prog_req == `PROG_REQ_12V) ? socket_power_pkg::PROG_12V :
    socket_power_pkg::PROG_OFF;

  assign PROG = !vcc_on ? socket_power_pkg::PROG_OFF :
    (is_basic ? basic_prog : enh_prog);

endmodule : power_request_decode

// [hdl/socket_power_control.sv]
`timescale 1ns/1ns
`include "socket_power_map.svh"
module socket_power_control (
  // Clock and resets
  input wire logic CLK,
  input wire logic RST,
  input wire logic HOST_RST,
  input wire logic PME_EN,
  // Socket register window
  input wire logic [11:0] REG_ADDR,
  input wire logic REG_WR,
  input wire logic REG_RD,
  input wire logic [7:0] REG_WDATA,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  // Card detect pins, active low
  input wire logic CD1_N,
  input wire logic CD2_N,
  // Supply select from the system control register
  input wire logic SYSTEM_SUPPLY_SELECT,
  // Socket power switch and output gate
  output logic SOCKET_OUTPUT_ENABLE,
  output logic VCC_5V_EN,
  output logic VCC_3V3_EN,
  output logic VPP_12V_EN,
  output logic VPP_VCC_EN,
  // State seen by the rest of the socket
  output logic SOCKET_POWER_STATUS,
  output logic LAYOUT_BASIC,
  output logic [7:0] GENERAL_CONTROL
);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [3:0] revision_reg;
  logic [7:0] power_control_reg;
  logic [7:0] power_control_next;
  logic [7:0] int_gen_reg;
  logic [7:0] int_gen_next;
  logic [7:0] rdata_reg;
  logic rvalid_reg;
  logic output_enable_reg;
  logic vcc5_reg;
  logic vcc3_reg;
  logic vpp12_reg;
  logic vppvcc_reg;
  logic [1:0] cd_n_sync;
  socket_power_pkg::layout_type layout;
  socket_power_pkg::supply_type supply;
  socket_power_pkg::prog_type prog;

  // ----------------------------------------------------------------
  // Card detect synchroniser
  // ----------------------------------------------------------------
  pin_sync #(
    .WIDTH(2)
  ) u_cd_sync (
    .CLK(CLK),
    .RST(RST),
    .PIN_IN({CD2_N, CD1_N}),
    .PIN_SYNC(cd_n_sync)
  );

  wire logic cd1_seen = ~cd_n_sync[0];
  wire logic cd2_seen = ~cd_n_sync[1];
  wire logic card_present = cd1_seen & cd2_seen;

  // ----------------------------------------------------------------
  // Address decode and reset domains
  // ----------------------------------------------------------------
  wire logic sel_rev = (REG_ADDR == `OFS_REVISION);
  wire logic sel_status = (REG_ADDR == `OFS_IF_STATUS);
  wire logic sel_pc = (REG_ADDR == `OFS_POWER_CONTROL);
  wire logic sel_igc = (REG_ADDR == `OFS_INT_GEN_CONTROL);
  wire logic wr_rev = REG_WR & sel_rev;
  wire logic wr_pc = REG_WR & sel_pc;
  wire logic wr_igc = REG_WR & sel_igc;
  wire logic preserve_clear = HOST_RST & ~PME_EN;

  // Layout follows the revision field
  assign layout = (revision_reg == `REVISION_BASIC) ?
    socket_power_pkg::LAYOUT_BASIC_MODE :
    socket_power_pkg::LAYOUT_ENHANCED_MODE;
  wire logic is_basic = (layout == socket_power_pkg::LAYOUT_BASIC_MODE);

  // Writable bits of power control in the active layout
  wire logic [7:0] pc_mask = is_basic ? `PC_BASIC_RW_MASK :
    `PC_ENH_RW_MASK;

  // Masked write keeps bits the layout does not own
  assign power_control_next = (power_control_reg & ~pc_mask) |
    (REG_WDATA & pc_mask);

  // Host reset keeps the preserved bits while PME is on
  assign int_gen_next = int_gen_reg &
    (preserve_clear ? 8'h00 : `IGC_PRESERVE_MASK);

  // Read views, reserved bits forced to zero
  wire logic [7:0] pc_read = power_control_reg & pc_mask;
  wire logic vcc_on = (supply != socket_power_pkg::SUPPLY_OFF);
  wire logic [7:0] status_read = ({7'h00, vcc_on} << `ST_POWER_BIT) |
    ({7'h00, cd2_seen} << `ST_CD2_BIT) |
    ({7'h00, cd1_seen} << `ST_CD1_BIT);
  wire logic [7:0] read_mux =
    sel_rev ? {4'h0, revision_reg} :
    sel_status ? status_read :
    sel_pc ? pc_read :
    sel_igc ? int_gen_reg : 8'h00;

  // ----------------------------------------------------------------
  // Power request decode
  // ----------------------------------------------------------------
  power_request_decode u_decode (
    .LAYOUT(layout),
    .POWER_CONTROL(power_control_reg),
    .SYSTEM_SUPPLY_SELECT(SYSTEM_SUPPLY_SELECT),
    .CARD_PRESENT(card_present),
    .SUPPLY(supply),
    .PROG(prog)
  );

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  // Revision field, global reset only
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      revision_reg <= `REVISION_RESET;
    else if (wr_rev)
      revision_reg <= REG_WDATA[3:0];
  end

  // Power control, preserved domain
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      power_control_reg <= `POWER_CONTROL_RESET;
    else if (preserve_clear)
      power_control_reg <= `POWER_CONTROL_RESET;
    else if (wr_pc)
      power_control_reg <= power_control_next;
  end

  // Interrupt and general control, bits 6-5 preserved
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
      int_gen_reg <= `INT_GEN_RESET;
    else if (HOST_RST)
      int_gen_reg <= int_gen_next;
    else if (wr_igc)
      int_gen_reg <= REG_WDATA;
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      rdata_reg <= 8'h00;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rdata_reg <= REG_RD ? read_mux : 8'h00;
      rvalid_reg <= REG_RD;
    end
  end

  // Socket drive outputs
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      output_enable_reg <= 1'b0;
      vcc5_reg <= 1'b0;
      vcc3_reg <= 1'b0;
      vpp12_reg <= 1'b0;
      vppvcc_reg <= 1'b0;
    end
    else
    begin
      output_enable_reg <= power_control_reg[`PC_OUTPUT_ENABLE_BIT];
      vcc5_reg <= (supply == socket_power_pkg::SUPPLY_5V);
      vcc3_reg <= (supply == socket_power_pkg::SUPPLY_3V3);
      vpp12_reg <= (prog == socket_power_pkg::PROG_12V);
      vppvcc_reg <= (prog == socket_power_pkg::PROG_FOLLOW);
    end
  end

  // Port drive
  assign REG_RDATA = rdata_reg;
  assign REG_RVALID = rvalid_reg;
  assign SOCKET_OUTPUT_ENABLE = output_enable_reg;
  assign VCC_5V_EN = vcc5_reg;
  assign VCC_3V3_EN = vcc3_reg;
  assign VPP_12V_EN = vpp12_reg;
  assign VPP_VCC_EN = vppvcc_reg;
  assign SOCKET_POWER_STATUS = vcc5_reg | vcc3_reg;
  assign LAYOUT_BASIC = is_basic;
  assign GENERAL_CONTROL = int_gen_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  // Write to power control that is not overridden by host reset
  sequence s_pc_write;
    wr_pc && !preserve_clear;
  endsequence

  // Stored value then copied to the drive register
  sequence s_pc_settle;
    ##2 1'b1;
  endsequence

  a_output_enable_follow: assert property (
    s_pc_write |-> s_pc_settle ##0
      (SOCKET_OUTPUT_ENABLE == $past(REG_WDATA[7], 2)))
    else $error("output enable does not follow bit 7");

  a_auto_switch_gate: assert property (
    is_basic && power_control_reg[5] && !card_present |=>
      !(VCC_5V_EN || VCC_3V3_EN))
    else $error("auto switch let power on without a card");

  a_basic_supply_off: assert property (
    is_basic && !power_control_reg[4] |=> !(VCC_5V_EN || VCC_3V3_EN))
    else $error("basic supply on with enable clear");

  a_basic_supply_sel: assert property (
    is_basic && power_control_reg[4] && !power_control_reg[5] &&
      SYSTEM_SUPPLY_SELECT |=> VCC_3V3_EN && !VCC_5V_EN)
    else $error("basic supply ignores the select input");

  a_basic_prog_off: assert property (
    is_basic && power_control_reg[1:0] == 2'h0 |=>
      !(VPP_12V_EN || VPP_VCC_EN))
    else $error("basic vpp on with request off");

  a_vpp_needs_vcc: assert property (
    (VPP_12V_EN || VPP_VCC_EN) |-> (VCC_5V_EN || VCC_3V3_EN))
    else $error("vpp driven without card supply");

  a_basic_reserved_zero: assert property (
    REG_RD && sel_pc && is_basic |=> (REG_RDATA & 8'h4c) == 8'h00)
    else $error("basic reserved bits read nonzero");

  a_enh_supply_map: assert property (
    !is_basic && power_control_reg[4:3] == 2'h2 |=>
      VCC_5V_EN && !VCC_3V3_EN)
    else $error("enhanced 5 V request not honoured");

  a_enh_prog_reserved: assert property (
    !is_basic && power_control_reg[1:0] == 2'h3 |=>
      !(VPP_12V_EN || VPP_VCC_EN))
    else $error("enhanced reserved vpp code drove vpp");

  a_enh_reserved_zero: assert property (
    REG_RD && sel_pc && !is_basic |=> (REG_RDATA & 8'h64) == 8'h00)
    else $error("enhanced reserved bits read nonzero");

  a_host_clear: assert property (
    preserve_clear |=> power_control_reg == 8'h00 &&
      (int_gen_reg & 8'h60) == 8'h00)
    else $error("host reset left preserved bits set");

  a_pme_preserve: assert property (
    HOST_RST && PME_EN && !wr_pc |=> $stable(power_control_reg) &&
      (int_gen_reg & 8'h60) == ($past(int_gen_reg) & 8'h60))
    else $error("host reset cleared bits while PME is on");

  a_pc_readback: assert property (
    REG_RD && sel_pc |=> REG_RVALID && REG_RDATA == $past(pc_read))
    else $error("power control read at 802h is wrong");

  a_igc_write: assert property (
    wr_igc && !HOST_RST ##1 REG_RD && sel_igc |=>
      REG_RDATA == $past(REG_WDATA, 2))
    else $error("general control does not read back");

  a_revision_basic: assert property (
    wr_rev && REG_WDATA[3:0] == 4'h2 |=> LAYOUT_BASIC)
    else $error("revision 0010b did not select basic");

  a_status_power: assert property (
    REG_RD && sel_status |=> REG_RDATA[6] == $past(vcc_on))
    else $error("status power bit disagrees with supply");

  a_basic_discard: assert property (
    s_pc_write and is_basic |=>
      power_control_reg[3] == $past(power_control_reg[3]))
    else $error("basic write changed a reserved bit");

  a_layout_keeps: assert property (
    wr_rev && !preserve_clear |=> $stable(power_control_reg))
    else $error("layout change altered stored fields");

endmodule : socket_power_control

// [test/card_socket_model.sv]
`timescale 1ns/1ns
// Card and power switch as seen from the socket
module card_socket_model (
  // Card seating: 0 empty, 1 partly in, 2 fully seated
  input wire logic [1:0] SEAT,
  // Power switch drive
  input wire logic VCC_5V_EN,
  input wire logic VCC_3V3_EN,
  input wire logic VPP_12V_EN,
  input wire logic VPP_VCC_EN,
  // Card detect pins, pulled up while open
  output logic CD1_N,
  output logic CD2_N,
  // Unsafe switch combination seen
  output logic FAULT
);
  // Detect pins ground as the card slides in, CD1 first
  assign CD1_N = (SEAT == 2'h0);
  assign CD2_N = (SEAT != 2'h2);
  // Two Vcc rails, two Vpp sources, or Vpp with no Vcc harm the card
  assign FAULT = (VCC_5V_EN & VCC_3V3_EN) | (VPP_12V_EN & VPP_VCC_EN) |
    ((VPP_12V_EN | VPP_VCC_EN) & ~(VCC_5V_EN | VCC_3V3_EN));
endmodule : card_socket_model

// [test/test_card_socket_power_control_regs.sv]
`timescale 1ns/1ns
module test_card_socket_power_control_regs;
  typedef struct packed
  {
    logic basic;
    logic sel;
    logic [1:0] seat;
    logic [7:0] wdata;
    logic [7:0] rdexp;
    logic [5:0] outexp;
  } row_type;
  logic clk, rst, host_rst, pme_en, reg_wr, reg_rd, reg_rvalid;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, general_control;
  logic cd1_n, cd2_n, sys_sel, oe, v5, v33, p12, pvcc, status;
  logic layout_basic, fault;
  logic [1:0] seat;
  logic [5:0] outs;
  logic [7:0] want;
  int n_fail = 0;
  int n_compared = 0;
  int cycles = 0;
  // Layout, select, seating, write, read back, {oe,5V,3V3,12V,Vcc,status}
  row_type rows [12] = '{
    '{1'b0, 1'b0, 2'h0, 8'h90, 8'h90, 6'h31},
    '{1'b0, 1'b0, 2'h0, 8'h1a, 8'h1a, 6'h0d},
    '{1'b0, 1'b0, 2'h0, 8'hff, 8'h9b, 6'h29},
    '{1'b0, 1'b0, 2'h0, 8'h02, 8'h02, 6'h00},
    '{1'b0, 1'b0, 2'h0, 8'h0b, 8'h0b, 6'h00},
    '{1'b0, 1'b0, 2'h1, 8'h12, 8'h12, 6'h15},
    '{1'b1, 1'b0, 2'h2, 8'hff, 8'hb3, 6'h31},
    '{1'b1, 1'b1, 2'h1, 8'h31, 8'h31, 6'h00},
    '{1'b1, 1'b1, 2'h0, 8'h11, 8'h11, 6'h0b},
    '{1'b1, 1'b0, 2'h0, 8'h12, 8'h12, 6'h15},
    '{1'b1, 1'b1, 2'h0, 8'h02, 8'h02, 6'h00},
    '{1'b1, 1'b0, 2'h2, 8'h31, 8'h31, 6'h13}};

  assign outs = {oe, v5, v33, p12, pvcc, status};

  // --------------------------------------------------------------
  // Design and card
  // --------------------------------------------------------------
  socket_power_control uut (
    .CLK(clk), .RST(rst), .HOST_RST(host_rst), .PME_EN(pme_en),
    .REG_ADDR(reg_addr), .REG_WR(reg_wr), .REG_RD(reg_rd),
    .REG_WDATA(reg_wdata), .REG_RDATA(reg_rdata),
    .REG_RVALID(reg_rvalid), .CD1_N(cd1_n), .CD2_N(cd2_n),
    .SYSTEM_SUPPLY_SELECT(sys_sel), .SOCKET_OUTPUT_ENABLE(oe),
    .VCC_5V_EN(v5), .VCC_3V3_EN(v33), .VPP_12V_EN(p12),
    .VPP_VCC_EN(pvcc), .SOCKET_POWER_STATUS(status),
    .LAYOUT_BASIC(layout_basic), .GENERAL_CONTROL(general_control));
  card_socket_model card (
    .SEAT(seat), .VCC_5V_EN(v5), .VCC_3V3_EN(v33), .VPP_12V_EN(p12),
    .VPP_VCC_EN(pvcc), .CD1_N(cd1_n), .CD2_N(cd2_n), .FAULT(fault));

  // --------------------------------------------------------------
  // Clock, timeout and helpers
  // --------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_fail++;
      $display("mismatch at %0t: timeout", $time);
      print_verdict;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp,
    input string what);
    n_compared++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what,
        seen, exp);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [7:0] exp);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01, "read valid");
    check(reg_rdata, exp, "read data");
  endtask : rd

  task print_verdict;
    $display("compared %0d, failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : print_verdict

  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    host_rst = 1'b0;
    pme_en = 1'b0;
    reg_addr = 12'h000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_wdata = 8'h00;
    seat = 2'h0;
    sys_sel = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    check({2'b00, outs}, 8'h00, "outputs after reset");
    rd(12'h801, 8'h00);
    rd(12'h800, 8'h04);
    rd(12'h802, 8'h00);
    rd(12'h803, 8'h00);
    wr(12'h803, 8'ha5);
    rd(12'h803, 8'ha5);
    check(general_control, 8'ha5, "general control");
    // Write then read back to back
    @(negedge clk);
    reg_addr = 12'h803;
    reg_wdata = 8'h5a;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    check({7'h00, reg_rvalid}, 8'h01, "back to back valid");
    check(reg_rdata, 8'h5a, "back to back read");
    wr(12'h9ff, 8'hff);
    rd(12'h9ff, 8'h00);
    // Table of layouts, requests and card seating
    for (int i = 0; i < 12; i++)
    begin
      sys_sel = rows[i].sel;
      seat = rows[i].seat;
      wr(12'h800, rows[i].basic ? 8'h02 : 8'h04);
      wr(12'h802, rows[i].wdata);
      rd(12'h802, rows[i].rdexp);
      want = {2'b00, rows[i].outexp};
      check({2'b00, outs}, want, "drive");
      check({7'h00, fault}, 8'h00, "unsafe switch");
      check({7'h00, layout_basic}, {7'h00, rows[i].basic}, "layout");
      rd(12'h801, {1'b0, rows[i].outexp[0], 2'b00, rows[i].seat == 2'h2,
        rows[i].seat != 2'h0, 2'b00});
    end
    // Layout change reinterprets stored fields, bit 5 kept from last row
    wr(12'h800, 8'h04);
    wr(12'h802, 8'h18);
    wr(12'h800, 8'h02);
    rd(12'h802, 8'h30);
    check({2'b00, outs}, 8'h11, "basic view");
    wr(12'h800, 8'h04);
    rd(12'h802, 8'h18);
    check({2'b00, outs}, 8'h09, "enhanced view");
    // Host reset with power events on keeps preserved fields
    wr(12'h800, 8'h02);
    wr(12'h802, 8'h90);
    wr(12'h803, 8'hff);
    pme_en = 1'b1;
    @(negedge clk);
    host_rst = 1'b1;
    @(negedge clk);
    host_rst = 1'b0;
    rd(12'h802, 8'h90);
    rd(12'h803, 8'h60);
    // Host reset with power events off wins over a same-cycle write
    pme_en = 1'b0;
    @(negedge clk);
    host_rst = 1'b1;
    reg_addr = 12'h802;
    reg_wdata = 8'hff;
    reg_wr = 1'b1;
    @(negedge clk);
    host_rst = 1'b0;
    reg_wr = 1'b0;
    rd(12'h802, 8'h00);
    rd(12'h803, 8'h00);
    rd(12'h800, 8'h02);
    check({7'h00, layout_basic}, 8'h01, "layout kept");
    // Global reset in mid-run clears power control and reloads revision 4
    wr(12'h802, 8'h90);
    rst = 1'b1;
    @(negedge clk);
    rst = 1'b0;
    rd(12'h800, 8'h04);
    rd(12'h802, 8'h00);
    check({1'b0, layout_basic, outs}, 8'h00, "global reset");
    print_verdict;
  end
endmodule : test_card_socket_power_control_regs
